// ===== design/usba_pkg.sv
// Constants, register map and carrier types for the shadow buffer alias
package usba_pkg;
  // Bus widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  // Sixteen aliases, one aligned word each; index 5 sits at 0x5000_1044
  localparam int unsigned ALIAS_COUNT = 16;
  localparam logic [31:0] ALIAS_BASE = 32'h5000_1030;
  localparam logic [31:0] ALIAS_5_ADDR = 32'h5000_1044;
  localparam logic [31:0] ALIAS_6_ADDR = 32'h5000_1048;
  localparam logic [31:0] ALIAS_STRIDE = 32'h0000_0004;
  // Control and status registers
  localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h5000_1100;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1104;
  localparam logic [31:0] MODE_ADDR = 32'h5000_1108;
  localparam logic [31:0] DIVISOR_ADDR = 32'h5000_110C;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_1110;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5000_1114;
  // Field positions
  localparam int unsigned FIFO_EN_BIT = 0;
  localparam int unsigned MODE_IR_BIT = 0;
  localparam int unsigned LS_READY_BIT = 0;
  localparam int unsigned LS_OE_BIT = 1;
  localparam int unsigned LS_HOLD_EMPTY_BIT = 5;
  localparam int unsigned LS_TEMT_BIT = 6;
  localparam int unsigned INT_RX_BIT = 0;
  localparam int unsigned INT_OE_BIT = 1;
  localparam int unsigned INT_TX_HOLDING_EMPTY_BIT = 2;
  localparam int unsigned INT_W = 3;
  // Reset values and sizes
  localparam logic [15:0] DIVISOR_RESET = 16'h0364;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  // Register bus request carrier
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } usba_bus_req_type;
endpackage

// ===== design/usba_sync2.sv
// Two-flop synchroniser for a pin input
`timescale 1ns/1ps
module usba_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // First flop feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== design/usba_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module usba_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [CW-1:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready = (count_reg != FULL_COUNT);
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rptr_reg];

  // Storage has no reset; only pointers and count need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // Pointers wrap at DEPTH so non-power-of-two depths work
  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == LAST_PTR) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == LAST_PTR) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end
endmodule

// ===== design/usba_shadow_buffer_alias.sv
// UART receive/transmit data path reached through sixteen shadow aliases
// Contract
// (R1) Sixteen 32-bit aliases: reads give receive data, writes feed transmit.
// (R2) Received byte lands in bits 7:0, from serial or infrared input.
// (R3) Master trusts read data only while rx_data_ready is set.
// (R4) FIFOs off: new byte overwrites unread one and flags overrun.
// (R5) FIFOs on: alias read returns head of receive FIFO.
// (R6) Receive FIFO full: keep contents, drop new byte, flag overrun.
// (R7) Master writes transmit data only while tx_holding_empty is set.
// (R8) FIFOs off: a write clears tx_holding_empty.
// (R9) FIFOs off: later writes before send replace pending character.
// (R10) FIFOs on: writes accepted until transmit FIFO of depth 16 fills.
// (R11) Writes while the transmit FIFO is full are discarded.
// (R12) Alias bits 15:8 read zero and ignore writes.
`timescale 1ns/1ps
module usba_shadow_buffer_alias #(
  parameter int unsigned FIFO_DEPTH = usba_pkg::FIFO_DEPTH,
  parameter int unsigned ALIAS_COUNT = usba_pkg::ALIAS_COUNT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire usba_pkg::usba_bus_req_type bus_req,
  output logic [31:0] rd_data,
  input wire logic sin,
  input wire logic sir_in,
  output logic sout,
  output logic sir_out_n,
  output logic irq
);
  localparam logic [31:0] ALIAS_SPAN = 32'(4 * (ALIAS_COUNT - 1));
  localparam logic [31:0] ALIAS_LAST = usba_pkg::ALIAS_BASE + ALIAS_SPAN;

  typedef enum logic [1:0] {
    LINK_IDLE, LINK_START, LINK_DATA, LINK_STOP
  } usba_link_state_type;

  // Control and status state
  logic fifo_en_reg;
  logic ir_reg;
  logic [15:0] div_reg;
  logic [usba_pkg::INT_W-1:0] int_status_reg;
  logic [usba_pkg::INT_W-1:0] int_mask_reg;
  logic [31:0] rd_data_reg;
  logic irq_reg;
  logic oe_reg;
  logic rx_avail_reg;
  logic [7:0] rx_buf_reg;
  logic hold_empty_reg;
  logic [7:0] hold_byte_reg;
  logic hold_empty_q_reg;

  // Receiver state
  usba_link_state_type rx_state_reg;
  usba_link_state_type rx_state_next;
  logic [15:0] rx_cnt_reg;
  logic [2:0] rx_bitn_reg;
  logic [7:0] rx_shift_reg;
  logic rx_mid_reg;
  logic rx_low_seen_reg;

  // Transmitter state
  usba_link_state_type tx_state_reg;
  usba_link_state_type tx_state_next;
  logic [15:0] tx_cnt_reg;
  logic [2:0] tx_bitn_reg;
  logic [7:0] tx_shift_reg;
  logic sout_reg;
  logic sir_out_n_reg;

  // Synchronised pins and FIFO wires
  logic sin_s;
  logic sir_in_s;
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic [7:0] rxf_out_data;
  logic txf_in_ready;
  logic txf_out_valid;
  logic [7:0] txf_out_data;

  // Address decoding
  wire [31:0] addr = bus_req.addr;
  wire alias_hit = (addr >= usba_pkg::ALIAS_BASE) && (addr <= ALIAS_LAST) &&
                   (addr[1:0] == 2'b00); // (R1)
  wire fctl_hit = (addr == usba_pkg::FIFO_CONTROL_ADDR);
  wire ls_hit = (addr == usba_pkg::LINE_STATUS_ADDR);
  wire mode_hit = (addr == usba_pkg::MODE_ADDR);
  wire div_hit = (addr == usba_pkg::DIVISOR_ADDR);
  wire ist_hit = (addr == usba_pkg::INT_STATUS_ADDR);
  wire imask_hit = (addr == usba_pkg::INT_MASK_ADDR);
  wire alias_rd = bus_req.rd && alias_hit;
  wire alias_wr = bus_req.wr && alias_hit;
  wire ls_rd = bus_req.rd && ls_hit;
  wire fctl_wr = bus_req.wr && fctl_hit;
  wire new_fifo_en = bus_req.wdata[usba_pkg::FIFO_EN_BIT];
  // Switching FIFO mode flushes both FIFOs so no stale bytes leak across
  wire fifo_flush = fctl_wr && (new_fifo_en != fifo_en_reg);
  wire [7:0] wr_byte = bus_req.wdata[7:0]; // (R12)

  // Bit timing shared by both directions; zero divisor acts as one
  wire [15:0] div_eff = (div_reg == 16'h0000) ? 16'h0001 : div_reg;
  wire [15:0] div_half = div_eff >> 1;
  wire [15:0] div_quarter = div_eff >> 2;
  wire [15:0] div_last = div_eff - 16'h0001;

  // Receive line: an infrared pulse marks a zero bit
  wire rx_raw = ir_reg ? ~sir_in_s : sin_s; // (R2)
  wire rx_bit_end = (rx_state_reg != LINK_IDLE) && (rx_cnt_reg == div_last);
  wire rx_mid_val = (rx_cnt_reg == div_half) ? rx_raw : rx_mid_reg;
  wire rx_ir_val = ~rx_low_seen_reg; // End sample is counted in neither bit
  wire rx_bit_val = ir_reg ? rx_ir_val : rx_mid_val; // (R2)
  wire rx_done = (rx_state_reg == LINK_STOP) && rx_bit_end;
  wire [7:0] rx_byte = rx_shift_reg;

  // Receive delivery: FIFO push, or overwrite of the single buffer
  wire rxf_push = rx_done && fifo_en_reg;
  wire rx_fifo_drop = rxf_push && !rxf_in_ready; // (R6)
  wire rx_buf_overrun = rx_done && !fifo_en_reg && rx_avail_reg &&
                        !alias_rd; // (R4)
  wire overrun_event = rx_fifo_drop || rx_buf_overrun;
  wire rxf_pop = alias_rd && fifo_en_reg; // (R5)
  wire rx_ready = fifo_en_reg ? rxf_out_valid : rx_avail_reg;
  wire [7:0] rx_head = fifo_en_reg ? rxf_out_data : rx_buf_reg; // (R5)

  // Transmit path
  wire txf_push = alias_wr && fifo_en_reg; // (R10)
  wire tx_load = (tx_state_reg == LINK_IDLE) &&
                 (fifo_en_reg ? txf_out_valid : !hold_empty_reg);
  wire txf_pop = tx_load && fifo_en_reg;
  wire [7:0] tx_src = fifo_en_reg ? txf_out_data : hold_byte_reg;
  wire tx_bit_end = (tx_state_reg != LINK_IDLE) && (tx_cnt_reg == div_last);
  wire hold_empty = fifo_en_reg ? !txf_out_valid : hold_empty_reg;
  wire temt = hold_empty && (tx_state_reg == LINK_IDLE);
  wire tx_level = (tx_state_reg == LINK_START) ? 1'b0 :
                  (tx_state_reg == LINK_DATA) ? tx_shift_reg[0] : 1'b1;
  wire ir_pulse = ir_reg && !tx_level && (tx_cnt_reg <= div_quarter);

  // Interrupt events and write-one-to-clear
  wire hold_empty_rise = hold_empty && !hold_empty_q_reg;
  wire [usba_pkg::INT_W-1:0] int_set =
      {hold_empty_rise, overrun_event, rx_done};
  wire [usba_pkg::INT_W-1:0] int_clr = (bus_req.wr && ist_hit) ?
      bus_req.wdata[usba_pkg::INT_W-1:0] : '0;
  wire [usba_pkg::INT_W-1:0] int_status_next =
      (int_status_reg & ~int_clr) | int_set;

  // Line status view; bits 7:0 hold the flags
  wire [7:0] line_status = {1'b0, temt, hold_empty, 3'b000, oe_reg, rx_ready};

  // Read data selection for the cycle after the strobe
  wire [31:0] rd_data_next =
      !bus_req.rd ? 32'h0000_0000 :
      alias_hit ? {24'h00_0000, rx_head} : // (R12)
      fctl_hit ? {31'h0000_0000, fifo_en_reg} :
      ls_hit ? {24'h00_0000, line_status} :
      mode_hit ? {31'h0000_0000, ir_reg} :
      div_hit ? {16'h0000, div_reg} :
      ist_hit ? {29'h0000_0000, int_status_reg} :
      imask_hit ? {29'h0000_0000, int_mask_reg} : 32'h0000_0000;

  // Pin synchronisers
  usba_sync2 #(.RESET_VAL(1'b1)) u_sync_sin (
    .clk(clk), .rst_b(rst_b), .d(sin), .q(sin_s)
  );
  usba_sync2 #(.RESET_VAL(1'b0)) u_sync_sir (
    .clk(clk), .rst_b(rst_b), .d(sir_in), .q(sir_in_s)
  );

  // Receive FIFO; a full FIFO refuses the push so stored bytes survive
  usba_fifo #(.WIDTH(usba_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk), .rst_b(rst_b), .flush(fifo_flush),
    .in_valid(rxf_push), .in_ready(rxf_in_ready), .in_data(rx_byte),
    .out_valid(rxf_out_valid), .out_ready(rxf_pop),
    .out_data(rxf_out_data)
  ); // (R6)

  // Transmit FIFO; a full FIFO refuses the write and the byte is lost
  usba_fifo #(.WIDTH(usba_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk), .rst_b(rst_b), .flush(fifo_flush),
    .in_valid(txf_push), .in_ready(txf_in_ready), .in_data(wr_byte),
    .out_valid(txf_out_valid), .out_ready(txf_pop),
    .out_data(txf_out_data)
  ); // (R11)

  // Software controlled registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fifo_en_reg <= 1'b0;
      ir_reg <= 1'b0;
      div_reg <= usba_pkg::DIVISOR_RESET;
      int_mask_reg <= '0;
    end else if (bus_req.wr) begin
      if (fctl_hit) fifo_en_reg <= new_fifo_en;
      if (mode_hit) ir_reg <= bus_req.wdata[usba_pkg::MODE_IR_BIT];
      if (div_hit) div_reg <= bus_req.wdata[15:0];
      if (imask_hit) int_mask_reg <= bus_req.wdata[usba_pkg::INT_W-1:0];
    end
  end

  // Read port, interrupt status and level interrupt output
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_reg <= 32'h0000_0000;
      int_status_reg <= '0;
      irq_reg <= 1'b0;
      hold_empty_q_reg <= 1'b1;
    end else begin
      rd_data_reg <= rd_data_next;
      int_status_reg <= int_status_next;
      irq_reg <= |(int_status_next & int_mask_reg);
      hold_empty_q_reg <= hold_empty;
    end
  end

  // Overrun flag clears on a line status read; a new event wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      oe_reg <= 1'b0;
    end else if (overrun_event) begin
      oe_reg <= 1'b1; // (R4) (R6)
    end else if (ls_rd) begin
      oe_reg <= 1'b0;
    end
  end

  // Single receive buffer used with FIFOs off; arrival beats a read
  always_ff @(posedge clk) begin
    if (!rst_b || fifo_flush) begin
      rx_avail_reg <= 1'b0;
      rx_buf_reg <= 8'h00;
    end else if (rx_done && !fifo_en_reg) begin
      rx_buf_reg <= rx_byte; // (R4)
      rx_avail_reg <= 1'b1;
    end else if (alias_rd && !fifo_en_reg) begin
      rx_avail_reg <= 1'b0; // (R3)
    end
  end

  // Single holding register; a write in the load cycle keeps it non-empty
  always_ff @(posedge clk) begin
    if (!rst_b || fifo_flush) begin
      hold_empty_reg <= 1'b1;
      hold_byte_reg <= 8'h00;
    end else if (alias_wr && !fifo_en_reg) begin
      hold_byte_reg <= wr_byte; // (R9)
      hold_empty_reg <= 1'b0; // (R8)
    end else if (tx_load && !fifo_en_reg) begin
      hold_empty_reg <= 1'b1;
    end
  end

  // Receiver next state; a high start sample is taken as noise
  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      LINK_IDLE: if (!rx_raw) rx_state_next = LINK_START;
      LINK_START: if (rx_bit_end) begin
        rx_state_next = rx_bit_val ? LINK_IDLE : LINK_DATA;
      end
      LINK_DATA: if (rx_bit_end && rx_bitn_reg == 3'h7) begin
        rx_state_next = LINK_STOP;
      end
      LINK_STOP: if (rx_bit_end) rx_state_next = LINK_IDLE;
      default: rx_state_next = LINK_IDLE;
    endcase
  end

  // Receiver bit timing and shift, least significant bit first
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_state_reg <= LINK_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_bitn_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_mid_reg <= 1'b1;
      rx_low_seen_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_mid_reg <= rx_mid_val;
      if (rx_state_reg == LINK_IDLE || rx_bit_end) begin
        rx_cnt_reg <= 16'h0000;
        rx_low_seen_reg <= 1'b0;
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
        rx_low_seen_reg <= rx_low_seen_reg | ~rx_raw;
      end
      if (rx_bit_end && rx_state_reg == LINK_DATA) begin
        rx_shift_reg <= {rx_bit_val, rx_shift_reg[7:1]}; // (R2)
        rx_bitn_reg <= rx_bitn_reg + 3'h1;
      end else if (rx_state_reg == LINK_START) begin
        rx_bitn_reg <= 3'h0;
      end
    end
  end

  // Transmitter next state
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      LINK_IDLE: if (tx_load) tx_state_next = LINK_START;
      LINK_START: if (tx_bit_end) tx_state_next = LINK_DATA;
      LINK_DATA: if (tx_bit_end && tx_bitn_reg == 3'h7) begin
        tx_state_next = LINK_STOP;
      end
      LINK_STOP: if (tx_bit_end) tx_state_next = LINK_IDLE;
      default: tx_state_next = LINK_IDLE;
    endcase
  end

  // Transmitter shift and registered pin drivers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_state_reg <= LINK_IDLE;
      tx_cnt_reg <= 16'h0000;
      tx_bitn_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      sout_reg <= 1'b1;
      sir_out_n_reg <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= (tx_state_reg == LINK_IDLE || tx_bit_end) ?
                    16'h0000 : tx_cnt_reg + 16'h0001;
      if (tx_load) begin
        tx_shift_reg <= tx_src;
        tx_bitn_reg <= 3'h0;
      end else if (tx_bit_end && tx_state_reg == LINK_DATA) begin
        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
        tx_bitn_reg <= tx_bitn_reg + 3'h1;
      end
      // Infrared mode parks the wired output high
      sout_reg <= ir_reg ? 1'b1 : tx_level;
      sir_out_n_reg <= ~ir_pulse;
    end
  end

  // Outputs come straight from flops
  assign rd_data = rd_data_reg;
  assign sout = sout_reg;
  assign sir_out_n = sir_out_n_reg;
  assign irq = irq_reg;
endmodule

// ===== dv/usba_sva.sv
// Concurrent checks on the shadow buffer alias ports
`timescale 1ns/1ps
module usba_sva #(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned ALIAS_COUNT = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire usba_pkg::usba_bus_req_type bus_req,
  input wire logic [31:0] rd_data,
  input wire logic sin,
  input wire logic sir_in,
  input wire logic sout,
  input wire logic sir_out_n,
  input wire logic irq
);
  logic [31:0] off;
  logic is_alias;
  logic is_unmap;
  logic [15:0] div_reg;
  logic [31:0] dv;
  logic ir_reg;
  logic [2:0] mask_reg;
  logic sout_q;
  logic [31:0] run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Decode; the whole control page counts as mapped, gaps included
  assign off = bus_req.addr - usba_pkg::ALIAS_BASE;
  assign is_alias = off < 32'(ALIAS_COUNT * 4) && off[1:0] == 2'b00;
  assign is_unmap = !is_alias && (bus_req.addr & 32'hFFFF_FFE0) !=
    usba_pkg::FIFO_CONTROL_ADDR;
  assign dv = (div_reg == 16'h0000) ? 32'h0000_0001 : 32'(div_reg);
  // Shadow copies of the settings that shape line timing and irq
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_reg <= usba_pkg::DIVISOR_RESET;
      ir_reg <= 1'b0;
      mask_reg <= 3'h0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == usba_pkg::DIVISOR_ADDR)
        div_reg <= bus_req.wdata[15:0];
      if (bus_req.addr == usba_pkg::MODE_ADDR)
        ir_reg <= bus_req.wdata[0];
      if (bus_req.addr == usba_pkg::INT_MASK_ADDR)
        mask_reg <= bus_req.wdata[2:0];
    end
  end
  // Length of the present sout level, in cycles
  always_ff @(posedge clk) begin
    sout_q <= sout;
    if (!rst_b || sout != sout_q) begin
      run <= 32'h0000_0001;
    end else begin
      run <= run + 32'h0000_0001;
    end
  end
  sequence alias_rd;
    bus_req.rd && is_alias;
  endsequence
  sequence sout_rise;
    sout && !sout_q;
  endsequence
  rd_idle_zero_a:
    assert property (!bus_req.rd |=> rd_data == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  alias_upper_zero_a:
    assert property (alias_rd |=> rd_data[31:8] == 24'h00_0000)
    else $error("alias read upper bits not zero");
  unmapped_zero_a:
    assert property (bus_req.rd && is_unmap |=> rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");
  status_upper_zero_a:
    assert property (bus_req.rd && bus_req.addr ==
      usba_pkg::LINE_STATUS_ADDR |=> rd_data[31:8] == 24'h00_0000)
    else $error("line status upper bits not zero");
  sout_bit_len_a:
    assert property (sout_rise |-> run % dv == 32'h0000_0000)
    else $error("low run on sout not whole bits");
  sout_stop_len_a:
    assert property ($fell(sout) |-> run >= dv)
    else $error("sout high run shorter than a bit");
  ir_quiet_uart_a:
    assert property (ir_reg && $past(ir_reg) |-> sout)
    else $error("sout moved in infrared mode");
  uart_quiet_ir_a:
    assert property (!ir_reg && !$past(ir_reg) |-> sir_out_n)
    else $error("infrared output moved in serial mode");
  irq_masked_a:
    assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
    else $error("irq high with all sources masked");
endmodule

bind usba_shadow_buffer_alias usba_sva #(
  .FIFO_DEPTH(FIFO_DEPTH),
  .ALIAS_COUNT(ALIAS_COUNT)
) usba_sva_i (
  .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
  .sin(sin), .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n),
  .irq(irq)
);

// ===== dv/usba_peer.sv
// Serial and infrared peer on the far side of the line
`timescale 1ns/1ps
module usba_peer #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic sout,
  input wire logic sir_out_n,
  output logic sin,
  output logic sir_in
);
  logic [7:0] got[$];
  int ir_falls = 0;
  // Lines idle: serial high, infrared dark
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  // One 8N1 frame, LSB first; infrared sends a short pulse per 0 bit
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < DIV; c++) begin
        @(posedge clk);
        sin <= ir | f[i];
        sir_in <= ir & !f[i] & (c < 2);
      end
    end
    @(posedge clk);
    sin <= 1'b1;
    sir_in <= 1'b0;
  endtask
  // Serial receiver, sampling mid-bit
  always begin
    logic [7:0] b;
    @(negedge sout);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      b[i] = sout;
    end
    repeat (DIV) @(posedge clk);
    got.push_back(b);
  end
  // Infrared pulse count; one pulse per 0 bit
  always @(negedge sir_out_n) ir_falls++;
endmodule

// ===== dv/usba_shadow_buffer_alias_tb.sv
// Self-checking bench for the shadow buffer alias
`timescale 1ns/1ps
module usba_shadow_buffer_alias_tb;
  localparam int DEPTH = 4;
  localparam int DIV = 4;
  localparam logic [31:0] LS = usba_pkg::LINE_STATUS_ADDR;
  localparam logic [31:0] A5 = usba_pkg::ALIAS_5_ADDR;
  localparam logic [31:0] AB = usba_pkg::ALIAS_BASE;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] e;
  } usba_row_type;
  // Reset rows: address beside the value a read must give
  usba_row_type rows [7] = '{
    '{A5, 32'h0000_0000}, '{usba_pkg::ALIAS_6_ADDR, 32'h0000_0000},
    '{LS, 32'h0000_0060}, '{usba_pkg::DIVISOR_ADDR, 32'h0000_0364},
    '{usba_pkg::INT_MASK_ADDR, 32'h0000_0000},
    '{usba_pkg::INT_STATUS_ADDR, 32'h0000_0000},
    '{32'h5000_1200, 32'h0000_0000}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  usba_pkg::usba_bus_req_type req = '0;
  logic [31:0] rd_data;
  logic sin;
  logic sir_in;
  logic sout;
  logic sir_out_n;
  logic irq;
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  usba_shadow_buffer_alias #(.FIFO_DEPTH(DEPTH), .ALIAS_COUNT(16))
  usba_shadow_buffer_alias_i (
    .clk(clk), .rst_b(rst_b), .bus_req(req), .rd_data(rd_data),
    .sin(sin), .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n),
    .irq(irq));
  usba_peer #(.DIV(DIV)) usba_peer_i (
    .clk(clk), .sout(sout), .sir_out_n(sir_out_n), .sin(sin),
    .sir_in(sir_in));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus cycles: one strobe cycle, then a quiet one
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [31:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
    chk(nm, e, d);
  endtask
  // Next byte seen on sout; an empty queue forces a mismatch
  task automatic txchk(input logic [7:0] e);
    logic [7:0] g;
    if (usba_peer_i.got.size() != 0) g = usba_peer_i.got.pop_front();
    else g = ~e;
    chk("tx byte", 32'(e), 32'(g));
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) rchk("reset row", rows[i].a, rows[i].e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, well past the longest expected run
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    do_reset();
    bus_wr(usba_pkg::DIVISOR_ADDR, DIV);
    // Single-buffer receive, read through the last alias
    usba_peer_i.send(8'hA5, 1'b0);
    repeat (6) @(posedge clk);
    rchk("ls ready", LS, 32'h0000_0061);
    rchk("rx top", AB + 32'h0000_003C, 32'h0000_00A5);
    rchk("ls read", LS, 32'h0000_0060);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    // Overrun: second byte replaces the unread one
    bus_wr(usba_pkg::INT_MASK_ADDR, 32'h0000_0002);
    usba_peer_i.send(8'h11, 1'b0);
    usba_peer_i.send(8'h22, 1'b0);
    repeat (6) @(posedge clk);
    chk("irq overrun", 32'h0000_0001, 32'(irq));
    rchk("ls overrun", LS, 32'h0000_0063);
    rchk("rx newest", A5, 32'h0000_0022);
    rchk("ls cleared", LS, 32'h0000_0060);
    bus_wr(usba_pkg::INT_STATUS_ADDR, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    // Single-buffer send: engine takes 41, 43 replaces 42
    bus_wr(A5, 32'h1234_5641);
    bus_wr(usba_pkg::ALIAS_6_ADDR, 32'h0000_0042);
    rchk("ls held", LS, 32'h0000_0000);
    bus_wr(A5, 32'hFFFF_FF43);
    repeat (120) @(posedge clk);
    txchk(8'h41);
    txchk(8'h43);
    chk("tx extra", 32'h0000_0000, 32'(usba_peer_i.got.size()));
    // FIFO receive: one byte past full is dropped
    bus_wr(usba_pkg::FIFO_CONTROL_ADDR, 32'h0000_0001);
    for (int i = 0; i <= DEPTH; i++) usba_peer_i.send(8'h10 + i, 1'b0);
    repeat (6) @(posedge clk);
    rchk("ls full", LS, 32'h0000_0063);
    for (int i = 0; i < DEPTH; i++)
      rchk("rx head", AB + 4 * i, 32'h0000_0010 + i);
    rchk("ls drained", LS, 32'h0000_0060);
    // FIFO send: engine plus DEPTH entries, the rest lost
    for (int i = 0; i < DEPTH + 2; i++)
      bus_wr(AB + 4 * i, 32'h0000_0030 + i);
    rchk("ls tx full", LS, 32'h0000_0000);
    repeat (240) @(posedge clk);
    for (int i = 0; i <= DEPTH; i++) txchk(8'h30 + i);
    chk("tx lost", 32'h0000_0000, 32'(usba_peer_i.got.size()));
    // Infrared receive and send
    bus_wr(usba_pkg::MODE_ADDR, 32'h0000_0001);
    usba_peer_i.ir_falls = 0;
    usba_peer_i.send(8'h5A, 1'b1);
    repeat (6) @(posedge clk);
    rchk("ir rx", A5, 32'h0000_005A);
    bus_wr(A5, 32'h0000_0000);
    repeat (60) @(posedge clk);
    chk("ir pulses", 32'h0000_0009, 32'(usba_peer_i.ir_falls));
    bus_wr(usba_pkg::MODE_ADDR, 32'h0000_0000);
    repeat (4) @(posedge clk);
    // Second reset in mid-run restores every reset value
    do_reset();
    conclude();
  end
endmodule
